// File: hdl/prl_pkg.sv
/*
 * Constants for the transceiver reset control and indicator select block:
 * register indices, field positions, reset values and source codes.
 * Assumes APB with 32-bit data, one register per aligned word.
 */
package prl_pkg;
   // printed offsets are register indices; byte address is four times the index
   localparam logic [7:0] PRL_IDX_RESET_CONTROL = 8'h1f;
   localparam logic [7:0] PRL_IDX_INDICATOR_CONFIG = 8'h25;
   localparam logic [7:0] PRL_IDX_BASIC_STATUS = 8'h01;
   localparam logic [7:0] PRL_IDX_TEST_ERR_CTRL = 8'h1b;
   localparam logic [7:0] PRL_IDX_PIN_STATUS = 8'h30;
   localparam int PRL_ADDR_W = 10;

   localparam int PRL_RC_FULL_BIT = 15;
   localparam int PRL_RC_RESTART_BIT = 14;
   localparam logic [15:0] PRL_RC_RW_MASK = 16'h3fff;
   localparam logic [15:0] PRL_RC_RESET = 16'h0000;

   localparam int PRL_IC_SWAP_BIT = 9;
   localparam int PRL_IC_SRC_LSB = 3;
   localparam int PRL_IC_EN_BIT = 0;
   localparam logic [15:0] PRL_IC_RW_MASK = 16'hfff9;
   localparam logic [15:0] PRL_IC_RESET = 16'h0041;

   localparam int PRL_TE_CLEAR_BIT = 15;

   // reset pulse widths in ns, converted to pclk cycles (min rounds up)
   localparam int PRL_CLK_NS = 25;
   localparam int PRL_FULL_RST_NS = 1000;
   localparam int PRL_RESTART_NS = 500;
   localparam int PRL_FULL_RST_CYC = (PRL_FULL_RST_NS + PRL_CLK_NS - 1) / PRL_CLK_NS;
   localparam int PRL_RESTART_CYC = (PRL_RESTART_NS + PRL_CLK_NS - 1) / PRL_CLK_NS;
   // blink half-period for code 8h
   localparam int PRL_BLINK_NS = 50000;
   localparam int PRL_BLINK_CYC = PRL_BLINK_NS / PRL_CLK_NS;

   typedef enum logic [3:0] {
      PRL_SRC_LINK = 4'h0, PRL_SRC_ACT = 4'h1, PRL_SRC_TXACT = 4'h2, PRL_SRC_RXACT = 4'h3,
      PRL_SRC_COL = 4'h4, PRL_SRC_S100 = 4'h5, PRL_SRC_S10 = 4'h6, PRL_SRC_FDX = 4'h7,
      PRL_SRC_LINKBLINK = 4'h8, PRL_SRC_STRETCH = 4'h9, PRL_SRC_L100FD = 4'ha, PRL_SRC_LPI = 4'hb,
      PRL_SRC_MIIERR = 4'hc, PRL_SRC_LOST = 4'hd, PRL_SRC_PRBS = 4'he, PRL_SRC_RSVD = 4'hf
   } prl_src_t;

   // gray-coded along idle -> full/restart -> idle
   typedef enum logic [1:0] {
      PRL_ST_IDLE = 2'b00, PRL_ST_FULL = 2'b01, PRL_ST_RESTART = 2'b10
   } prl_state_t;
endpackage : prl_pkg

// File: hdl/prl_phy_reset_led.sv
/*
 * Reset control and multi-function indicator select for the transceiver.
 * Assumes an APB master on pclk, status sources synchronous to pclk, and
 * the strap level on the secondary indicator pin stable from reset release.
 */
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

//Behaviour
// RQ1: writing one to the full-reset bit pulses a whole-device reset like the reset pin, then the bit clears; here the latches and the strap are not reset.
// RQ2: writing one to the restart bit pulses a circuitry restart that keeps registers, then the bit clears.
// RQ3: in enhanced mode a pull-up strap gives an active-low indicator and a pull-down strap active-high.
// RQ4: in basic mode the indicator is always active low.
// RQ5: a four-bit source field resetting to 8h selects link, activity, collision, speed or duplex sources.
// RQ6: codes 8h to Ch select link-blink, stretched activity, 100 full duplex, low-power idle and media error.
// RQ7: code Dh lights on link loss and stays lit until the basic status register is read.
// RQ8: code Eh lights on a pattern error and stays lit until the test error counter is cleared.
// RQ9: with routing enabled the selected source drives the indicator; zero is reserved for software.
// RQ10: writing one to the top bit of the test control register clears the error count and the latch.
// RQ11: the polarity-swap bit inverts the strap-derived polarity in enhanced mode.
module prl_phy_reset_led
   import prl_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PRL_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic enhanced_mode,
   input wire logic secondary_strap_pullup,
   input wire logic link_up,
   input wire logic speed_100,
   input wire logic full_duplex,
   input wire logic tx_active,
   input wire logic rx_active,
   input wire logic collision,
   input wire logic stretched_activity,
   input wire logic lpi_active,
   input wire logic mii_error,
   input wire logic prbs_error,
   output logic full_reset_pulse,
   output logic restart_pulse,
   output logic test_err_clear,
   output logic status_read,
   output logic primary_indicator_pin
);
   localparam logic [15:0] BLINK_MAX = 16'(PRL_BLINK_CYC - 1);

   function automatic logic [PRL_ADDR_W-1:0] reg_addr(input logic [7:0] idx);
      reg_addr = PRL_ADDR_W'({idx, 2'b00});
   endfunction : reg_addr

   logic wr, rd, setup_rd;
   logic hit_rc, hit_ic, hit_bs, hit_te, hit_ps;
   logic [15:0] rc_q, rc_d, ic_q, ic_d;
   prl_state_t st_q, st_d;
   logic [5:0] cnt_q, cnt_d;
   logic strap_q, strap_d, strap_ok_q;
   logic lost_q, lost_d, prbs_q, prbs_d, link_q;
   logic [15:0] blink_q, blink_d;
   logic blink_ph_q, blink_ph_d;
   logic [31:0] rdata_d, prdata_q;
   logic raw, active_low, led_d, led_q;
   logic [15:0] wmask;

   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign setup_rd = psel && !penable && !pwrite;
   assign hit_rc = paddr == reg_addr(PRL_IDX_RESET_CONTROL);
   assign hit_ic = paddr == reg_addr(PRL_IDX_INDICATOR_CONFIG);
   assign hit_bs = paddr == reg_addr(PRL_IDX_BASIC_STATUS);
   assign hit_te = paddr == reg_addr(PRL_IDX_TEST_ERR_CTRL);
   assign hit_ps = paddr == reg_addr(PRL_IDX_PIN_STATUS);
   assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   assign pready = 1'b1;
   assign pslverr = psel && penable && !(hit_rc || hit_ic || hit_bs || hit_te || hit_ps);
   assign prdata = prdata_q;
   assign test_err_clear = wr && hit_te && pstrb[1] && pwdata[PRL_TE_CLEAR_BIT]; // see RQ10
   assign status_read = rd && hit_bs;
   assign full_reset_pulse = (st_q == PRL_ST_FULL);
   assign restart_pulse = (st_q == PRL_ST_RESTART);
   assign primary_indicator_pin = led_q;

   // register file and self-clearing reset sequencer
   always_comb begin
      rc_d = rc_q;
      ic_d = ic_q;
      st_d = st_q;
      cnt_d = cnt_q;
      rdata_d = prdata_q;
      if (wr && hit_rc) begin
         rc_d = (rc_q & ~(wmask & PRL_RC_RW_MASK)) | (pwdata[15:0] & wmask & PRL_RC_RW_MASK);
      end
      if (wr && hit_ic) begin
         ic_d = (ic_q & ~(wmask & PRL_IC_RW_MASK)) | (pwdata[15:0] & wmask & PRL_IC_RW_MASK);
      end
      case (st_q)
         PRL_ST_IDLE: begin
            if (wr && hit_rc && pstrb[1] && pwdata[PRL_RC_FULL_BIT]) begin
               st_d = PRL_ST_FULL; // see RQ1
               cnt_d = 6'(PRL_FULL_RST_CYC - 1);
            end else if (wr && hit_rc && pstrb[1] && pwdata[PRL_RC_RESTART_BIT]) begin
               st_d = PRL_ST_RESTART; // see RQ2
               cnt_d = 6'(PRL_RESTART_CYC - 1);
            end
         end
         PRL_ST_FULL, PRL_ST_RESTART: begin
            if (cnt_q == 6'h00) begin
               st_d = PRL_ST_IDLE;
            end else begin
               cnt_d = cnt_q - 6'h01;
            end
         end
         default: st_d = PRL_ST_IDLE;
      endcase
      // a full reset returns the configuration to defaults; a restart keeps it
      if (st_q == PRL_ST_FULL && cnt_q == 6'h00) begin
         rc_d = PRL_RC_RESET; // see RQ1
         ic_d = PRL_IC_RESET;
      end
      // captured in the setup phase so the word stands through the zero-wait access phase
      if (setup_rd) begin
         if (hit_rc) begin
            rdata_d = {16'h0000, rc_q | ({15'h0000, st_q == PRL_ST_FULL} << PRL_RC_FULL_BIT)
                      | ({15'h0000, st_q == PRL_ST_RESTART} << PRL_RC_RESTART_BIT)};
         end else if (hit_ic) begin
            rdata_d = {16'h0000, ic_q};
         end else if (hit_ps) begin
            rdata_d = {30'h0, active_low, led_q};
         end else begin
            rdata_d = 32'h00000000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rc_q <= PRL_RC_RESET;
         ic_q <= PRL_IC_RESET;
         st_q <= PRL_ST_IDLE;
         cnt_q <= 6'h00;
         prdata_q <= 32'h00000000;
      end else begin
         rc_q <= rc_d;
         ic_q <= ic_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         prdata_q <= rdata_d;
      end
   end

   // strap caught on the first clock after reset release; held until next reset
   always_comb begin
      strap_d = strap_ok_q ? strap_q : secondary_strap_pullup;
      // latches: set wins over clear
      lost_d = lost_q;
      if (status_read) begin
         lost_d = 1'b0;
      end
      if (link_q && !link_up) begin
         lost_d = 1'b1; // see RQ7
      end
      prbs_d = prbs_q;
      if (test_err_clear) begin
         prbs_d = 1'b0; // see RQ10
      end
      if (prbs_error) begin
         prbs_d = 1'b1; // see RQ8
      end
      blink_d = (blink_q == BLINK_MAX) ? 16'h0000 : blink_q + 16'h0001;
      blink_ph_d = (blink_q == BLINK_MAX) ? !blink_ph_q : blink_ph_q;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_q <= 1'b1;
         strap_ok_q <= 1'b0;
         lost_q <= 1'b0;
         prbs_q <= 1'b0;
         link_q <= 1'b0;
         blink_q <= 16'h0000;
         blink_ph_q <= 1'b0;
         led_q <= 1'b1;
      end else begin
         strap_q <= strap_d;
         strap_ok_q <= 1'b1;
         lost_q <= lost_d;
         prbs_q <= prbs_d;
         link_q <= link_up;
         blink_q <= blink_d;
         blink_ph_q <= blink_ph_d;
         led_q <= led_d;
      end
   end

   // source select and polarity
   always_comb begin
      case (prl_src_t'(ic_q[PRL_IC_SRC_LSB +: 4])) // see RQ5
         PRL_SRC_LINK: raw = link_up;
         PRL_SRC_ACT: raw = tx_active || rx_active;
         PRL_SRC_TXACT: raw = tx_active;
         PRL_SRC_RXACT: raw = rx_active;
         PRL_SRC_COL: raw = collision;
         PRL_SRC_S100: raw = speed_100;
         PRL_SRC_S10: raw = !speed_100;
         PRL_SRC_FDX: raw = full_duplex;
         PRL_SRC_LINKBLINK: raw = link_up && !((tx_active || rx_active) && blink_ph_q); // see RQ6
         PRL_SRC_STRETCH: raw = stretched_activity;
         PRL_SRC_L100FD: raw = link_up && speed_100 && full_duplex;
         PRL_SRC_LPI: raw = lpi_active;
         PRL_SRC_MIIERR: raw = mii_error;
         PRL_SRC_LOST: raw = lost_q; // see RQ7
         PRL_SRC_PRBS: raw = prbs_q; // see RQ8
         default: raw = 1'b0;
      endcase
      // polarity: basic mode forces active low, enhanced follows the strap
      if (!enhanced_mode) begin
         active_low = 1'b1; // see RQ4
      end else begin
         active_low = strap_q ^ ic_q[PRL_IC_SWAP_BIT]; // see RQ3, see RQ11
      end
      // routing disabled (reserved) leaves the indicator off
      led_d = (ic_q[PRL_IC_EN_BIT] && raw) ^ active_low; // see RQ9
   end

   a_rst_full_len: assert property (@(posedge pclk) disable iff (!presetn) // see RQ1
      $rose(full_reset_pulse) |-> full_reset_pulse [*8] ##33 !full_reset_pulse)
      else $error("full reset pulse length wrong");
   a_rst_start: assert property (@(posedge pclk) disable iff (!presetn) // see RQ1
      (wr && hit_rc && pstrb[1] && pwdata[PRL_RC_FULL_BIT] && st_q == PRL_ST_IDLE) |=> full_reset_pulse)
      else $error("full reset not started");
   a_full_defaults: assert property (@(posedge pclk) disable iff (!presetn) // see RQ1
      $fell(full_reset_pulse) |-> (ic_q == PRL_IC_RESET && rc_q == PRL_RC_RESET))
      else $error("full reset left configuration");
   a_rst_restart: assert property (@(posedge pclk) disable iff (!presetn) // see RQ2
      $rose(restart_pulse) |-> restart_pulse [*8] ##1 restart_pulse [*8] ##1 restart_pulse [*4]
      ##1 !restart_pulse)
      else $error("restart pulse length wrong");
   a_restart_begin: assert property (@(posedge pclk) disable iff (!presetn) // see RQ2
      (wr && hit_rc && pstrb[1] && !pwdata[PRL_RC_FULL_BIT] && pwdata[PRL_RC_RESTART_BIT]
      && st_q == PRL_ST_IDLE) |=> restart_pulse)
      else $error("restart not started");
   a_restart_keep: assert property (@(posedge pclk) disable iff (!presetn) // see RQ2
      (restart_pulse && !wr) |=> $stable(ic_q))
      else $error("restart changed configuration");
   a_basic_low: assert property (@(posedge pclk) disable iff (!presetn) // see RQ4
      !enhanced_mode |-> active_low)
      else $error("basic mode not active low");
   a_enh_pol: assert property (@(posedge pclk) disable iff (!presetn) // see RQ3
      (enhanced_mode && strap_ok_q) |-> (active_low == (strap_q != ic_q[PRL_IC_SWAP_BIT])))
      else $error("enhanced polarity wrong");
   a_strap_hold: assert property (@(posedge pclk) disable iff (!presetn) // see RQ3
      strap_ok_q |=> $stable(strap_q))
      else $error("strap level moved");
   a_enh_pullup: assert property (@(posedge pclk) disable iff (!presetn) // see RQ3
      (ic_q[PRL_IC_SRC_LSB +: 4] == PRL_SRC_LINK && ic_q[PRL_IC_EN_BIT] && enhanced_mode && strap_ok_q
      && strap_q && !ic_q[PRL_IC_SWAP_BIT]) |=> (led_q == !$past(link_up)))
      else $error("pull-up strap not active low");
   a_enh_pulldown: assert property (@(posedge pclk) disable iff (!presetn) // see RQ3
      (ic_q[PRL_IC_SRC_LSB +: 4] == PRL_SRC_LINK && ic_q[PRL_IC_EN_BIT] && enhanced_mode && strap_ok_q
      && !strap_q && !ic_q[PRL_IC_SWAP_BIT]) |=> (led_q == $past(link_up)))
      else $error("pull-down strap not active high");
   a_enh_swap: assert property (@(posedge pclk) disable iff (!presetn) // see RQ11
      (ic_q[PRL_IC_SRC_LSB +: 4] == PRL_SRC_LINK && ic_q[PRL_IC_EN_BIT] && enhanced_mode && strap_ok_q
      && !strap_q && ic_q[PRL_IC_SWAP_BIT]) |=> (led_q == !$past(link_up)))
      else $error("polarity swap not applied");
   a_led_link: assert property (@(posedge pclk) disable iff (!presetn) // see RQ5
      (ic_q[PRL_IC_SRC_LSB +: 4] == PRL_SRC_LINK && ic_q[PRL_IC_EN_BIT] && $stable(ic_q) && !enhanced_mode)
      |=> (led_q == !$past(link_up)))
      else $error("link source not routed");
   a_src_tx: assert property (@(posedge pclk) disable iff (!presetn) // see RQ5
      (ic_q[PRL_IC_SRC_LSB +: 4] == PRL_SRC_TXACT && ic_q[PRL_IC_EN_BIT] && !enhanced_mode)
      |=> (led_q == !$past(tx_active)))
      else $error("transmit source not routed");
   a_rd_data: assert property (@(posedge pclk) disable iff (!presetn) // see RQ5
      (psel && !penable && !pwrite && hit_ic) |=> (prdata == {16'h0000, $past(ic_q)}))
      else $error("config read data wrong");
   a_src_lpi: assert property (@(posedge pclk) disable iff (!presetn) // see RQ6
      (ic_q[PRL_IC_SRC_LSB +: 4] == PRL_SRC_LPI && ic_q[PRL_IC_EN_BIT] && !enhanced_mode)
      |=> (led_q == !$past(lpi_active)))
      else $error("low-power source not routed");
   a_blink_link: assert property (@(posedge pclk) disable iff (!presetn) // see RQ6
      (ic_q[PRL_IC_SRC_LSB +: 4] == PRL_SRC_LINKBLINK && ic_q[PRL_IC_EN_BIT] && !enhanced_mode && link_up
      && !tx_active && !rx_active) |=> !led_q)
      else $error("quiet link not lit");
   a_lost_set: assert property (@(posedge pclk) disable iff (!presetn) // see RQ7
      (link_q && !link_up) |=> lost_q)
      else $error("link loss not latched");
   a_lost_clear: assert property (@(posedge pclk) disable iff (!presetn) // see RQ7
      (status_read && !(link_q && !link_up)) |=> !lost_q)
      else $error("link lost latch not released");
   a_lost_hold: assert property (@(posedge pclk) disable iff (!presetn) // see RQ7
      (lost_q && !status_read) |=> lost_q)
      else $error("link lost latch dropped");
   a_prbs_set: assert property (@(posedge pclk) disable iff (!presetn) // see RQ8
      prbs_error |=> prbs_q)
      else $error("pattern error not latched");
   a_prbs_clear: assert property (@(posedge pclk) disable iff (!presetn) // see RQ10
      (test_err_clear && !prbs_error) |=> !prbs_q)
      else $error("pattern latch not cleared");
   c_full: cover property (@(posedge pclk) disable iff (!presetn) $fell(full_reset_pulse));
   c_restart: cover property (@(posedge pclk) disable iff (!presetn) $fell(restart_pulse));
   c_lost: cover property (@(posedge pclk) disable iff (!presetn) $rose(lost_q) ##[1:50] status_read);
   c_swap: cover property (@(posedge pclk) disable iff (!presetn) enhanced_mode && ic_q[PRL_IC_SWAP_BIT]);
   c_pattern: cover property (@(posedge pclk) disable iff (!presetn) $rose(prbs_q) ##[1:50] test_err_clear);
endmodule : prl_phy_reset_led

`default_nettype wire

// File: sim/prl_led_model.sv
/* led on the primary indicator pin, wired to the supply or to ground.
   assumes the bench tells it which pin level lights it (active_low). */
`timescale 1ns/100ps
`default_nettype none
module prl_led_model (
   input wire logic pin,
   input wire logic active_low,
   output logic lit
);
   // lights only at its active level; an unknown pin never reads as lit
   assign lit = active_low ? (pin === 1'b0) : (pin === 1'b1);
endmodule : prl_led_model
`default_nettype wire

// File: sim/prl_phy_reset_led_tb.sv
/* self-checking bench for the reset control and indicator select block.
   assumes an apb master of its own, status sources as plain levels and
   the led model on the indicator pin; every wait is bounded. */
`timescale 1ns/100ps
`default_nettype none
module prl_phy_reset_led_tb
   import prl_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [PRL_ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er, lit, tc, sr;
   logic enhanced_mode = 1'b0;
   logic strap = 1'b1;
   logic swap = 1'b0;
   // {link, s100, fdx, tx, rx, col, stretch, lpi, mii_err, prbs_err}
   logic [9:0] src = 10'h000;
   logic full_reset_pulse, restart_pulse, test_err_clear, status_read, pin;
   int fail_count = 0;
   int samples_checked = 0;

   initial begin
      forever #12.5 pclk = ~pclk;
   end

   prl_phy_reset_led DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .enhanced_mode(enhanced_mode), .secondary_strap_pullup(strap), .link_up(src[9]), .speed_100(src[8]),
      .full_duplex(src[7]), .tx_active(src[6]), .rx_active(src[5]), .collision(src[4]),
      .stretched_activity(src[3]), .lpi_active(src[2]), .mii_error(src[1]), .prbs_error(src[0]),
      .full_reset_pulse(full_reset_pulse), .restart_pulse(restart_pulse), .test_err_clear(test_err_clear),
      .status_read(status_read), .primary_indicator_pin(pin));

   prl_led_model led (.pin(pin), .active_low(enhanced_mode ? (strap ^ swap) : 1'b1), .lit(lit));

   task automatic final_report;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask : chk

   // read data, error and side pulses are all taken at the completing edge
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      er = pslverr;
      tc = test_err_clear;
      sr = status_read;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fail_count++;
         final_report();
      end
   endtask : apb

   task automatic drive(input logic [9:0] v);
      @(posedge pclk);
      src <= v;
      repeat (4) @(posedge pclk);
      #1;
   endtask : drive

   task automatic t_regs;
      apb(1'b0, PRL_IDX_RESET_CONTROL, 32'h0);
      chk("reset_control", rd, 32'h0);
      apb(1'b0, PRL_IDX_INDICATOR_CONFIG, 32'h0);
      chk("indicator_config", rd, 32'h41);
      apb(1'b0, 8'h3e, 32'h0);
      chk("unmapped err", er, 32'h1);
   endtask : t_regs

   task automatic t_resets(input logic full);
      int nf, nr;
      nf = 0;
      nr = 0;
      apb(1'b1, PRL_IDX_INDICATOR_CONFIG, 32'h51);
      apb(1'b1, PRL_IDX_RESET_CONTROL, full ? 32'h8000 : 32'h4000);
      #1;
      repeat (70) begin
         nf += (full_reset_pulse === 1'b1);
         nr += (restart_pulse === 1'b1);
         @(posedge pclk);
         #1;
      end
      chk("full pulse", nf, full ? 40 : 0);
      chk("restart pulse", nr, full ? 0 : 20);
      apb(1'b0, PRL_IDX_INDICATOR_CONFIG, 32'h0);
      chk("config kept", rd, full ? 32'h41 : 32'h51);
      apb(1'b0, PRL_IDX_RESET_CONTROL, 32'h0);
      chk("self clear", rd, 32'h0);
   endtask : t_resets

   task automatic t_sources;
      logic [3:0] code [13] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 4'ha, 4'hb, 4'hc};
      logic [9:0] on_v [13] = '{10'h200, 10'h040, 10'h040, 10'h020, 10'h010, 10'h300, 10'h200, 10'h280,
         10'h200, 10'h008, 10'h380, 10'h004, 10'h002};
      logic [9:0] off_v [13] = '{0, 0, 10'h020, 10'h040, 0, 10'h200, 10'h300, 10'h200, 0, 0, 10'h300, 0, 0};
      for (int i = 0; i < 13; i++) begin
         apb(1'b1, PRL_IDX_INDICATOR_CONFIG, {25'h0, code[i], 3'b001});
         drive(on_v[i]);
         chk("source on", lit, 32'h1);
         chk("basic low", pin, 32'h0);
         drive(off_v[i]);
         chk("source off", lit, 32'h0);
      end
      // software keeps routing enabled; zero there is reserved
      apb(1'b0, PRL_IDX_INDICATOR_CONFIG, 32'h0);
      chk("routing kept", rd, 32'h61);
   endtask : t_sources

   task automatic t_latch;
      // earlier link drops may have set the latch: release it first
      drive(10'h200);
      apb(1'b0, PRL_IDX_BASIC_STATUS, 32'h0);
      chk("status read pulse", sr, 32'h1);
      apb(1'b1, PRL_IDX_INDICATOR_CONFIG, 32'h69);
      drive(10'h200);
      chk("lost idle", lit, 32'h0);
      drive(10'h000);
      chk("link lost", lit, 32'h1);
      drive(10'h200);
      chk("lost held", lit, 32'h1);
      apb(1'b0, PRL_IDX_BASIC_STATUS, 32'h0);
      drive(10'h200);
      chk("lost released", lit, 32'h0);
      apb(1'b1, PRL_IDX_INDICATOR_CONFIG, 32'h71);
      drive(10'h001);
      drive(10'h000);
      chk("pattern held", lit, 32'h1);
      apb(1'b1, PRL_IDX_TEST_ERR_CTRL, 32'h8000);
      chk("clear pulse", tc, 32'h1);
      drive(10'h000);
      chk("pattern cleared", lit, 32'h0);
   endtask : t_latch

   // the strap is only taken at reset release, so each case resets again
   task automatic t_polarity;
      for (int k = 0; k < 8; k++) begin
         @(posedge pclk);
         presetn <= 1'b0;
         enhanced_mode <= k[2];
         strap <= k[1];
         repeat (4) @(posedge pclk);
         presetn <= 1'b1;
         swap <= k[0];
         apb(1'b1, PRL_IDX_INDICATOR_CONFIG, {22'h0, k[0], 9'h001});
         drive(10'h200);
         chk("polarity on", lit, 32'h1);
         drive(10'h000);
         chk("polarity off", lit, 32'h0);
      end
   endtask : t_polarity

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_resets(1'b1);
      t_resets(1'b0);
      t_sources();
      t_latch();
      t_polarity();
      final_report();
   end
endmodule : prl_phy_reset_led_tb
`default_nettype wire
